// File: io_decoder_consts.vh
// constants for the input/output instruction decoder
`ifndef IO_DECODER_CONSTS_VH
`define IO_DECODER_CONSTS_VH
`define IOD_GROUP_PAT    3'b011
`define IOD_CPU_CODE     6'h3f
`define IOD_OP_NONE      3'b000
`define IOD_OP_DIN       3'b001
`define IOD_OP_DOUT      3'b010
`define IOD_OP_PRD       3'b011
`define IOD_OP_PWR       3'b100
`define IOD_OP_RSTRD     3'b101
`define IOD_OP_CMD       3'b110
`define IOD_OP_SKIP      3'b111
`define IOD_CT_NONE      2'b00
`define IOD_CT_SET       2'b01
`define IOD_CT_CLR       2'b10
`define IOD_CT_PULSE     2'b11
`define IOD_ADDR_INSTR   4'h0
`define IOD_ADDR_AC0     4'h1
`define IOD_ADDR_STATUS  4'h2
`define IOD_ADDR_RESULT  4'h3
`define IOD_ADDR_PFAIL   4'h4
`define IOD_ADDR_PTRMUX  4'h5
`define IOD_ADDR_PTRDSC  4'h6
`define IOD_ADDR_PTRTAP  4'h7
`define IOD_ADDR_AC3     4'h4
`define IOD_PEND_BIT     15
`define IOD_HTRANS_NSEQ  2'b10
`endif

// File: io_instruction_decoder.v
// input/output instruction decoder with ahb-lite register port
`timescale 1ns/1ns
`include "io_decoder_consts.vh"

// How it works
// - bits 0-2 equal 011 mark i/o
// - bits 3-4 pick accumulator for transfers
// - bits 10-15 carry device code
// - codes 00-76 devices, 77 processor
// - device code driven on select lines
// - opcode 000 moves no data
// - opcode 001 reads status or data
// - opcode 010 writes command or data
// - control field ignored for peripherals
// - fixed device code assignments by type
// - code 77 is processor control
// - set pulse enables interrupts, one delay
// - clear pulse disables interrupts
// - mask-out above one loads device disable from lsb
// - mask-out one disables, zero enables dma
// - io reset clears flags and masks
// - io reset pulses peripheral board
// - io reset implies clear pulse
// - command-out hands over to monitor
// - interrupts-on and power-fail flags testable
// - control bits select control block pointer
// - pointer read returns pointer, msb pending
// - dsc and tap pointer writes start or stop transfer
// - multiplexer pointer set, not started
// - opcode 111 skips on processor flags
module io_instruction_decoder #(
  parameter DW = 16
) (
  input  wire          hclk,
  input  wire          hresetn,
  input  wire          hsel,
  input  wire [31:0]   haddr,
  input  wire [1:0]    htrans,
  input  wire          hwrite,
  input  wire [2:0]    hsize,
  input  wire [31:0]   hwdata,
  input  wire          hready,
  output reg  [31:0]   hrdata,
  output reg           hreadyout,
  output reg           hresp,
  input  wire [DW-1:0] dev_rdata,
  input  wire          power_fail,
  input  wire [2:0]    ctl_pending,
  input  wire          dev_int_req,
  output reg  [5:0]    dev_select,
  output reg  [2:0]    dev_op,
  output reg           dev_strobe,
  output reg           dev_data_sel,
  output reg  [DW-1:0] dev_wdata,
  output reg           dev_int_disable,
  output reg           dma_disable,
  output reg           peripheral_reset_pulse,
  output reg           dma_start_dsc,
  output reg           dma_start_tap,
  output reg           dma_stop_dsc,
  output reg           dma_stop_tap,
  output reg           console_monitor,
  output reg           int_request
);

  reg [DW-1:0] acc_r [0:3];
  reg [DW-1:0] ptr_r [0:2];
  reg          interrupt_on_flag_r;
  reg          ion_arm_r;
  reg          ion_live_r;
  reg          interrupt_mask_state_r;
  reg          pend_clr_r;
  reg          skip_r;
  reg          illegal_r;
  reg          was_io_r;
  reg          ph_wr_r;
  reg          ph_rd_r;
  reg [3:0]    ph_addr_r;
  reg [DW-1:0] exec_r;
  integer      i;

  function is_io;
    input [DW-1:0] w;
    begin
      is_io = (w[DW-1:DW-3] == `IOD_GROUP_PAT);
    end
  endfunction

  function [1:0] fld_ac;
    input [DW-1:0] w;
    begin
      fld_ac = w[DW-4:DW-5];
    end
  endfunction

  function [2:0] fld_op;
    input [DW-1:0] w;
    begin
      fld_op = w[DW-6:DW-8];
    end
  endfunction

  function [1:0] fld_ct;
    input [DW-1:0] w;
    begin
      fld_ct = w[DW-9:DW-10];
    end
  endfunction

  function [5:0] fld_dev;
    input [DW-1:0] w;
    begin
      fld_dev = w[5:0];
    end
  endfunction

  // mask-out and the dsc and tap pointer writes both test the accumulator for zero
  function is_zero;
    input [DW-1:0] v;
    begin
      is_zero = (v == {DW{1'b0}});
    end
  endfunction

  function is_one;
    input [DW-1:0] v;
    begin
      is_one = (v == {{(DW-1){1'b0}}, 1'b1});
    end
  endfunction

  wire          bus_go   = hsel & hready & (htrans == `IOD_HTRANS_NSEQ);
  wire          exec_now = ph_wr_r & (ph_addr_r == `IOD_ADDR_INSTR);
  wire [DW-1:0] w        = hwdata[DW-1:0];
  wire [1:0]    ac_sel   = fld_ac(w);
  wire [2:0]    op       = fld_op(w);
  wire [1:0]    ct       = fld_ct(w);
  wire [5:0]    dev      = fld_dev(w);
  wire          cpu      = (dev == `IOD_CPU_CODE);
  wire [DW-1:0] acv      = acc_r[ac_sel];
  wire [1:0]    pidx     = ct - 2'd1;

  // only the low window decodes; higher addresses must not alias onto it
  wire          in_map   = (haddr[31:6] == 26'h0000000);

  // accumulator window: word offsets one to four
  wire          acc_wr   = ph_wr_r && (ph_addr_r >= `IOD_ADDR_AC0)
                           && (ph_addr_r <= `IOD_ADDR_AC0 + 4'd3);
  wire [1:0]    acc_idx  = ph_addr_r[1:0] - 2'd1;

  // pointer read: pending bit folds in the controller's live request
  wire          ptr_pend = ptr_r[pidx][DW-1] | ctl_pending[pidx];
  wire [DW-1:0] ptr_view = {ptr_pend, ptr_r[pidx][DW-2:0]};
  wire          acv_zero = is_zero(acv);
  wire          acv_one  = is_one(acv);

  // masked device requests never reach the processor; power fail bypasses the mask but still needs interrupts on
  wire          irq_src  = power_fail | (dev_int_req & ~interrupt_mask_state_r);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_r   <= 1'b0;
      ph_rd_r   <= 1'b0;
      ph_addr_r <= 4'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      // zero wait states: every access completes in its data phase
      ph_wr_r   <= bus_go & hwrite & in_map;
      ph_rd_r   <= bus_go & ~hwrite & in_map;
      ph_addr_r <= haddr[5:2];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // read data registered in data phase start; reads return current state
  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h0000_0000;
    if (in_map) begin
      case (haddr[5:2])
      `IOD_ADDR_INSTR:  rd_nxt[DW-1:0] = exec_r;
      `IOD_ADDR_STATUS: rd_nxt[6:0] = {was_io_r, illegal_r, skip_r, interrupt_mask_state_r,
                                       dma_disable, power_fail, interrupt_on_flag_r};
      `IOD_ADDR_RESULT: rd_nxt[DW-1:0] = acc_r[0];
      `IOD_ADDR_PTRMUX: rd_nxt[DW-1:0] = ptr_r[0];
      `IOD_ADDR_PTRDSC: rd_nxt[DW-1:0] = ptr_r[1];
      `IOD_ADDR_PTRTAP: rd_nxt[DW-1:0] = ptr_r[2];
      default:          rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_go & ~hwrite) begin
      hrdata <= rd_nxt;
    end
  end

  // request follows the gate one cycle late; io reset drops it on the edge after it executes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_request <= 1'b0;
    end else if (pend_clr_r) begin
      int_request <= 1'b0;
    end else begin
      int_request <= ion_live_r & interrupt_on_flag_r & irq_src;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < 4; i = i + 1)
        acc_r[i] <= {DW{1'b0}};
      for (i = 0; i < 3; i = i + 1)
        ptr_r[i] <= {DW{1'b0}};
      interrupt_on_flag_r    <= 1'b0;
      ion_arm_r              <= 1'b0;
      ion_live_r             <= 1'b0;
      interrupt_mask_state_r <= 1'b0;
      pend_clr_r             <= 1'b0;
      skip_r                 <= 1'b0;
      illegal_r              <= 1'b0;
      was_io_r               <= 1'b0;
      exec_r                 <= {DW{1'b0}};
      dev_select             <= 6'h00;
      dev_op                 <= 3'b000;
      dev_strobe             <= 1'b0;
      dev_data_sel           <= 1'b0;
      dev_wdata              <= {DW{1'b0}};
      dev_int_disable        <= 1'b0;
      dma_disable            <= 1'b0;
      peripheral_reset_pulse <= 1'b0;
      dma_start_dsc          <= 1'b0;
      dma_start_tap          <= 1'b0;
      dma_stop_dsc           <= 1'b0;
      dma_stop_tap           <= 1'b0;
      console_monitor        <= 1'b0;
    end else begin
      dev_strobe             <= 1'b0;
      peripheral_reset_pulse <= 1'b0;
      dma_start_dsc          <= 1'b0;
      dma_start_tap          <= 1'b0;
      dma_stop_dsc           <= 1'b0;
      dma_stop_tap           <= 1'b0;
      pend_clr_r             <= 1'b0;
      // interrupt honoured only after one further instruction
      if (exec_now) begin
        ion_live_r <= ion_arm_r;
        ion_arm_r  <= interrupt_on_flag_r;
      end
      if (acc_wr)
        acc_r[acc_idx] <= w;
      if (exec_now) begin
        exec_r   <= w;
        was_io_r <= is_io(w);
        skip_r   <= 1'b0;
        illegal_r <= ~is_io(w);
        if (is_io(w) && !cpu) begin
          // peripheral path: ctrl field deliberately dropped
          dev_select   <= dev;
          dev_op       <= op;
          dev_data_sel <= dev[0];
          dev_wdata    <= acv;
          dev_strobe   <= 1'b1;
          if (op == `IOD_OP_DIN)
            acc_r[ac_sel] <= dev_rdata;
          // opcode 000 and others leave accumulators untouched
        end else if (is_io(w)) begin
          case (op)
            `IOD_OP_NONE: begin
              if (ct == `IOD_CT_SET) begin
                interrupt_on_flag_r <= 1'b1;
                // armed now, so the next instruction makes it live
                ion_arm_r           <= 1'b1;
                ion_live_r          <= 1'b0;
              end else if (ct == `IOD_CT_CLR) begin
                interrupt_on_flag_r <= 1'b0;
                ion_arm_r           <= 1'b0;
                ion_live_r          <= 1'b0;
              end
            end
            `IOD_OP_PRD: begin
              if (ct != `IOD_CT_NONE)
                acc_r[ac_sel] <= ptr_view;
            end
            `IOD_OP_PWR: begin
              if (ct == `IOD_CT_NONE) begin
                // the two small values steer dma, larger ones the devices
                if (acv_one)
                  dma_disable <= 1'b1;
                else if (acv_zero)
                  dma_disable <= 1'b0;
                else begin
                  dev_int_disable        <= acv[0];
                  interrupt_mask_state_r <= acv[0];
                end
              end else begin
                ptr_r[pidx] <= acv;
                if (ct == `IOD_CT_CLR) begin
                  dma_start_dsc <= ~acv_zero;
                  dma_stop_dsc  <= acv_zero;
                end else if (ct == `IOD_CT_PULSE) begin
                  dma_start_tap <= ~acv_zero;
                  dma_stop_tap  <= acv_zero;
                end
              end
            end
            `IOD_OP_RSTRD: begin
              // control field ignored: always acts as the clear pulse
              interrupt_on_flag_r    <= 1'b0;
              ion_arm_r              <= 1'b0;
              ion_live_r             <= 1'b0;
              pend_clr_r             <= 1'b1;
              dma_disable            <= 1'b0;
              interrupt_mask_state_r <= 1'b0;
              dev_int_disable        <= 1'b0;
              // control block pointers are left as they are
              peripheral_reset_pulse <= 1'b1;
            end
            `IOD_OP_CMD: begin
              console_monitor <= 1'b1;
            end
            `IOD_OP_SKIP: begin
              case (ct)
                2'b00:   skip_r <= interrupt_on_flag_r;
                2'b01:   skip_r <= ~interrupt_on_flag_r;
                2'b10:   skip_r <= power_fail;
                default: skip_r <= ~power_fail;
              endcase
            end
            default: illegal_r <= 1'b0;
          endcase
        end
      end
    end
  end

endmodule

// File: decoder_checker_assertions.sv
// port assertions for the i/o instruction decoder
`timescale 1ns/1ns
module decoder_checker (
  input wire       hclk,
  input wire       hresetn,
  input wire [5:0] dev_select,
  input wire       dev_strobe,
  input wire       dev_data_sel,
  input wire       dev_int_disable,
  input wire       dma_disable,
  input wire       peripheral_reset_pulse,
  input wire       dma_start_dsc,
  input wire       dma_stop_dsc,
  input wire       console_monitor
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_iss; dev_strobe; endsequence
  sequence s_cpu; peripheral_reset_pulse || dma_start_dsc; endsequence
  property p_pulse; s_iss |=> !dev_strobe; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe held");
  property p_cpu; s_iss |-> dev_select != 6'h3f; endproperty
  a_cpu: assert property (p_cpu) else $error("strobe on processor code");
  property p_dsel; s_iss |-> dev_data_sel == dev_select[0]; endproperty
  a_dsel: assert property (p_dsel) else $error("register pick wrong");
  property p_rst;
    peripheral_reset_pulse |-> !dma_disable && !dev_int_disable ##1 !peripheral_reset_pulse;
  endproperty
  a_rst: assert property (p_rst) else $error("reset left state");
  property p_dma; dma_start_dsc |-> !dma_stop_dsc ##1 !dma_start_dsc; endproperty
  a_dma: assert property (p_dma) else $error("start pulse bad");
  property p_stop; dma_stop_dsc |=> !dma_stop_dsc; endproperty
  a_stop: assert property (p_stop) else $error("stop pulse held");
  property p_quiet; s_cpu |-> !dev_strobe; endproperty
  a_quiet: assert property (p_quiet) else $error("device strobed");
  property p_halt; $rose(console_monitor) |=> console_monitor [*4]; endproperty
  a_halt: assert property (p_halt) else $error("halt dropped");
endmodule
bind io_instruction_decoder decoder_checker u_chk (.hclk, .hresetn, .dev_select, .dev_strobe, .dev_data_sel,
  .dev_int_disable, .dma_disable, .peripheral_reset_pulse, .dma_start_dsc, .dma_stop_dsc, .console_monitor);

// File: periph_model.sv
// stand-in for one peripheral interface on the device bus
`timescale 1ns/1ns
module periph_model #(
  parameter [5:0] CODE = 6'h29
) (
  input  wire        hclk,
  input  wire        dev_strobe,
  input  wire [5:0]  dev_select,
  input  wire [15:0] dev_wdata,
  output wire [15:0] dev_rdata,
  output reg  [15:0] got
);
  // code is never 00; word offered before the code settles, so fixed
  assign dev_rdata = {10'h168, CODE};
  initial got = 16'h0000;
  always @(posedge hclk) begin
    if (dev_strobe && dev_select == CODE)
      got <= dev_wdata;
  end
endmodule

// File: io_instruction_decoder_tb_top.sv
// self-checking bench for the i/o instruction decoder
`timescale 1ns/1ns
module io_instruction_decoder_tb_top;
  typedef struct packed {logic [15:0] w; logic st; logic [15:0] wd;} row_t;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, power_fail = 0, dev_int_req = 0;
  logic [1:0] htrans = 0;
  logic [2:0] ctl_pending = 0, dev_op;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [15:0] dev_rdata, dev_wdata, got;
  logic [5:0] dev_select;
  logic hreadyout, hresp, dev_strobe, dev_data_sel, dev_int_disable, dma_disable, int_request;
  logic peripheral_reset_pulse, dma_start_dsc, dma_start_tap, dma_stop_dsc, dma_stop_tap, console_monitor;
  int error_cnt = 0, checks_done = 0;
  row_t rows[6];
  always #10 hclk = ~hclk;
  io_instruction_decoder dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .dev_rdata, .power_fail, .ctl_pending, .dev_int_req,
    .dev_select, .dev_op, .dev_strobe, .dev_data_sel, .dev_wdata, .dev_int_disable, .dma_disable,
    .peripheral_reset_pulse, .dma_start_dsc, .dma_start_tap, .dma_stop_dsc, .dma_stop_tap,
    .console_monitor, .int_request);
  periph_model pm (.hclk, .dev_strobe, .dev_select, .dev_wdata, .dev_rdata, .got);
  function automatic logic [15:0] ins(input logic [1:0] a, input logic [2:0] o, input logic [1:0] c,
                                      input logic [5:0] d);
    return {3'b011, a, o, c, d};
  endfunction
  task automatic summarize;
    if (error_cnt == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rdy;
    int k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 16);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      summarize;
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    rdy;
    htrans <= 2'b00;
    hwdata <= d;
    rdy;
    r = hrdata;
  endtask
  // outputs land after the execute edge, so look mid-cycle
  task automatic ex(input logic [15:0] w);
    bus(1, 32'h00, w);
    @(negedge hclk);
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    bus(0, 32'h08, 0);
    chk(r, 0);
    for (int n = 0; n < 4; n++)
      bus(1, 4 + 4 * n, 16'h1111 * n);
    rows = '{'{ins(2, 3'h2, 0, 6'h08), 1, 16'h2222}, '{ins(3, 3'h2, 3, 6'h29), 1, 16'h3333},
             '{ins(1, 3'h0, 0, 6'h30), 1, 0}, '{16'h0000, 0, 0}, '{16'h8029, 0, 0},
             '{ins(0, 3'h7, 0, 6'h3f), 0, 0}};
    foreach (rows[i]) begin
      ex(rows[i].w);
      chk(dev_strobe, rows[i].st);
      if (rows[i].st)
        chk(dev_select, rows[i].w[5:0]);
      if (rows[i].w[10:8] == 3'h2)
        chk(dev_wdata, rows[i].wd);
    end
    chk(got, 16'h3333);
    ex(ins(0, 3'h1, 0, 6'h29));
    bus(0, 32'h0c, 0);
    chk(r, 32'h5a29);
    dev_int_req <= 1;
    ex(ins(0, 3'h0, 1, 6'h3f));
    chk(int_request, 0);
    ex(ins(0, 3'h0, 0, 6'h30));
    @(negedge hclk);
    chk(int_request, 1);
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        ex(ins(0, 3'h7, c[1:0], 6'h3f));
        bus(0, 32'h08, 0);
        chk(r[1:0], {p[0], 1'b1});
        chk(r[4], (c[1] ? p[0] : 1'b1) ^ c[0]);
      end
      power_fail <= 1;
    end
    ex(ins(0, 3'h0, 2, 6'h3f));
    @(negedge hclk);
    chk(int_request, 0);
    for (int v = 3; v >= 0; v--) begin
      bus(1, 32'h04, v);
      ex(ins(0, 3'h4, 0, 6'h3f));
      if (v > 1)
        chk(dev_int_disable, v[0]);
      else
        chk(dma_disable, v[0]);
    end
    bus(1, 32'h04, 16'h1234);
    ctl_pending <= 3'h2;
    power_fail <= 0;
    ex(ins(0, 3'h4, 2, 6'h3f));
    chk(dma_start_dsc, 1);
    bus(1, 32'h04, 16'h0567);
    ex(ins(0, 3'h4, 1, 6'h3f));
    chk({dma_start_dsc, dma_start_tap}, 0);
    bus(0, 32'h14, 0);
    chk(r, 32'h0567);
    ex(ins(0, 3'h3, 2, 6'h3f));
    bus(0, 32'h0c, 0);
    chk(r, 32'h9234);
    bus(1, 32'h04, 0);
    ex(ins(0, 3'h4, 3, 6'h3f));
    chk(dma_stop_tap, 1);
    for (int v = 1; v < 4; v += 2) begin
      bus(1, 32'h04, v);
      ex(ins(0, 3'h4, 0, 6'h3f));
    end
    ex(ins(0, 3'h0, 1, 6'h3f));
    // set pulse given on purpose: reset must still clear
    ex(ins(0, 3'h5, 1, 6'h3f));
    chk(peripheral_reset_pulse, 1);
    chk({dma_disable, dev_int_disable}, 0);
    bus(0, 32'h08, 0);
    chk(r[3:0] & 4'hd, 0);
    bus(0, 32'h18, 0);
    chk(r[14:0], 15'h1234);
    bus(0, 32'h40, 0);
    chk(r, 0);
    ex(ins(0, 3'h6, 0, 6'h3f));
    chk(console_monitor, 1);
    summarize;
  end
endmodule
